// File: rtl/rblt_pkg.sv
// constants shared by the radio block loopback test controller
// assumes a single 10 MHz clock and a plain strobed register port
`default_nettype none
package rblt_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int NUM_SLOTS = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DL_MASK = 8'h04;
	localparam logic [7:0] OFS_UL_MASK = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_LB_COUNT = 8'h10;

	// control register fields
	localparam int CTRL_MULTI_EN_BIT = 0;
	localparam int CTRL_UL_NO_8PSK_BIT = 1;

	// status register fields
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_SUB_ON_BIT = 1;
	localparam int STAT_REQ_BIT = 2;
	localparam int STAT_DL_OFS_LSB = 4;
	localparam int STAT_DL_CNT_LSB = 8;
	localparam int STAT_UL_CNT_LSB = 12;

	// reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] DL_MASK_RST = 8'h01;
	localparam logic [7:0] UL_MASK_RST = 8'h01;

	// payload type codes, header bits 8 and 7
	localparam logic [1:0] PT_ON_NO_OPT = 2'h0;
	localparam logic [1:0] PT_OFF_NO_OPT = 2'h1;
	localparam logic [1:0] PT_ON_OPT1 = 2'h2;
	localparam logic [1:0] PT_OFF_RSVD = 2'h3;

	// resend of an 8PSK block over GMSK
	localparam logic [1:0] GMSK_SPAN_BLOCKS = 2'h3;
	localparam logic [1:0] NORMAL_SPAN_BLOCKS = 2'h1;
	localparam logic [4:0] GMSK_DROP_BITS = 5'h10;

	typedef enum logic [1:0] {
		RBLT_IDLE,
		RBLT_REQ,
		RBLT_ACTIVE
	} rblt_state_t;
endpackage
`default_nettype wire

// File: rtl/rblt_ctrl.sv
// switched radio block loopback controller, mobile side
// assumes all inputs synchronous to clock; radio events are 1-cycle pulses
//
// Added by the designer: strobed register access and the address map.
`default_nettype none
module rblt_ctrl #(
	parameter int SLOTS = rblt_pkg::NUM_SLOTS
) (
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire logic [rblt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rblt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [rblt_pkg::DATA_W-1:0] reg_rdata,
	// test command and flow events
	input wire logic start_cmd,
	input wire logic [2:0] start_dl_offset,
	input wire logic ul_assigned,
	input wire logic tbf_release,
	input wire logic t3190_expired,
	// received block descriptor, before channel decoding
	input wire logic rx_valid,
	input wire logic [2:0] rx_tn,
	input wire logic rx_is_ctrl,
	input wire logic [1:0] rx_payload_type,
	input wire logic rx_hdr_ok,
	input wire logic rx_is_8psk,
	input wire logic rx_tbf_msg,
	// flow control toward the protocol stack
	output logic ul_tbf_req,
	output logic ul_rlc_unack,
	output logic loop_active,
	output logic sub_on,
	output logic llc_block,
	output logic tbf_hold_open,
	output logic t3180_disable,
	output logic t3164_disable,
	output logic own_tx_inhibit,
	output logic rlcmac_fwd,
	output logic ctrl_obey,
	output logic ul_tx_stop,
	output logic ul_discard,
	output logic to_packet_idle,
	// loopback request to the uplink physical layer
	output logic lb_valid,
	output logic [2:0] lb_dl_tn,
	output logic [7:0] lb_ul_slots,
	output logic [1:0] lb_span,
	output logic [4:0] lb_drop_bits
);
	function automatic logic [3:0] count_ones(input logic [7:0] m);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < 8; i++) begin
			c = c + {3'h0, m[i]};
		end
		return c;
	endfunction

	// position of tn among active slots, counted from start with wrap
	function automatic logic [3:0] rank_from(input logic [7:0] m,
			input logic [2:0] start, input logic [2:0] tn);
		logic [3:0] c;
		logic hit;
		logic [2:0] idx;
		c = 4'h0;
		hit = 1'b0;
		idx = 3'h0;
		for (int i = 0; i < 8; i++) begin
			idx = start + 3'(i);
			if (idx == tn)
				hit = 1'b1;
			else if (!hit && m[idx])
				c = c + 4'h1;
		end
		return c;
	endfunction

	// uplink slots of rank k from TN0, or rank k and above when ext
	function automatic logic [7:0] ul_pick(input logic [7:0] m,
			input logic [3:0] k, input logic ext);
		logic [7:0] sel;
		logic [3:0] r;
		sel = 8'h00;
		r = 4'h0;
		for (int i = 0; i < 8; i++) begin
			if (m[i]) begin
				sel[i] = (r == k) || (ext && r > k);
				r = r + 4'h1;
			end
		end
		return sel;
	endfunction

	rblt_pkg::rblt_state_t state_r, state_nxt;
	logic [1:0] ctrl_r;
	logic [7:0] dl_mask_r;
	logic [7:0] ul_mask_r;
	logic [2:0] dl_ofs_r;
	logic sub_on_r;
	logic [15:0] lb_count_r;

	// register port decode
	wire logic wr_ctrl = reg_wr && reg_addr == rblt_pkg::OFS_CTRL;
	wire logic wr_dl = reg_wr && reg_addr == rblt_pkg::OFS_DL_MASK;
	wire logic wr_ul = reg_wr && reg_addr == rblt_pkg::OFS_UL_MASK;
	wire logic wr_cnt = reg_wr && reg_addr == rblt_pkg::OFS_LB_COUNT;
	wire logic multi_en = ctrl_r[rblt_pkg::CTRL_MULTI_EN_BIT];
	wire logic ul_no_8psk = ctrl_r[rblt_pkg::CTRL_UL_NO_8PSK_BIT];

	wire logic [3:0] dl_cnt = count_ones(dl_mask_r);
	wire logic [3:0] ul_cnt = count_ones(ul_mask_r);
	wire logic in_loop = state_r == rblt_pkg::RBLT_ACTIVE;
	wire logic terminate = (tbf_release || t3190_expired)
		&& state_r != rblt_pkg::RBLT_IDLE;

	// downlink slot rank from the commanded offset
	wire logic [3:0] dl_rank = rank_from(dl_mask_r, dl_ofs_r, rx_tn);
	wire logic dl_is_last = dl_rank == dl_cnt - 4'h1;
	wire logic use_map = multi_en && dl_cnt > 4'h1;
	// uplink ranks always count from TN0
	wire logic [7:0] map_slots = ul_pick(ul_mask_r, dl_rank,
		dl_is_last);
	wire logic [7:0] ul_slots = use_map ? map_slots : ul_mask_r;

	// sub-mode switch on control blocks, bit 7 of header picks OFF
	wire logic pt_off = rx_payload_type == rblt_pkg::PT_OFF_NO_OPT
		|| rx_payload_type == rblt_pkg::PT_OFF_RSVD;
	wire logic sub_cmd = in_loop && rx_valid && rx_is_ctrl;
	wire logic sub_on_nxt = sub_cmd ? !pt_off : sub_on_r;
	// the switching block itself follows the sub-mode in force on arrival
	wire logic do_loop = in_loop && rx_valid && sub_on_r
		&& |ul_slots;
	wire logic resend_gmsk = rx_is_8psk && ul_no_8psk;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			rblt_pkg::RBLT_IDLE:
				if (start_cmd)
					state_nxt = rblt_pkg::RBLT_REQ;
			rblt_pkg::RBLT_REQ:
				if (terminate)
					state_nxt = rblt_pkg::RBLT_IDLE;
				else if (ul_assigned)
					state_nxt = rblt_pkg::RBLT_ACTIVE;
			rblt_pkg::RBLT_ACTIVE:
				if (terminate)
					state_nxt = rblt_pkg::RBLT_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst)
			state_r <= rblt_pkg::RBLT_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_r <= rblt_pkg::CTRL_RST;
			dl_mask_r <= rblt_pkg::DL_MASK_RST;
			ul_mask_r <= rblt_pkg::UL_MASK_RST;
		end else begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata[1:0];
			if (wr_dl)
				dl_mask_r <= reg_wdata[7:0];
			if (wr_ul)
				ul_mask_r <= reg_wdata[7:0];
		end
	end

	// offset latched with the command so later changes cannot renumber
	always_ff @(posedge clock) begin
		if (rst)
			dl_ofs_r <= 3'h0;
		else if (start_cmd && state_r == rblt_pkg::RBLT_IDLE)
			dl_ofs_r <= start_dl_offset;
	end

	always_ff @(posedge clock) begin
		if (rst)
			sub_on_r <= 1'b1;
		else if (state_r != rblt_pkg::RBLT_ACTIVE)
			sub_on_r <= 1'b1;
		else
			sub_on_r <= sub_on_nxt;
	end

	// loopback counter: hardware increment wins over software clear
	always_ff @(posedge clock) begin
		if (rst)
			lb_count_r <= 16'h0000;
		else if (do_loop)
			lb_count_r <= lb_count_r + 16'h0001;
		else if (wr_cnt)
			lb_count_r <= 16'h0000;
	end

	// flow control outputs, all registered
	always_ff @(posedge clock) begin
		if (rst) begin
			ul_tbf_req <= 1'b0;
			ul_rlc_unack <= 1'b0;
			loop_active <= 1'b0;
			sub_on <= 1'b0;
			llc_block <= 1'b0;
			tbf_hold_open <= 1'b0;
			t3180_disable <= 1'b0;
			t3164_disable <= 1'b0;
			own_tx_inhibit <= 1'b0;
		end else begin
			ul_tbf_req <= state_r == rblt_pkg::RBLT_IDLE && start_cmd;
			ul_rlc_unack <= state_nxt != rblt_pkg::RBLT_IDLE;
			loop_active <= state_nxt == rblt_pkg::RBLT_ACTIVE;
			sub_on <= state_nxt == rblt_pkg::RBLT_ACTIVE
				&& (in_loop ? sub_on_nxt : 1'b1);
			llc_block <= state_nxt != rblt_pkg::RBLT_IDLE;
			tbf_hold_open <= state_nxt == rblt_pkg::RBLT_ACTIVE;
			t3180_disable <= state_nxt == rblt_pkg::RBLT_ACTIVE;
			t3164_disable <= state_nxt == rblt_pkg::RBLT_ACTIVE;
			own_tx_inhibit <= state_nxt == rblt_pkg::RBLT_ACTIVE
				&& (in_loop ? sub_on_nxt : 1'b1);
		end
	end

	// per-block and termination pulses
	always_ff @(posedge clock) begin
		if (rst) begin
			rlcmac_fwd <= 1'b0;
			ctrl_obey <= 1'b0;
			ul_tx_stop <= 1'b0;
			ul_discard <= 1'b0;
			to_packet_idle <= 1'b0;
		end else begin
			// outside sub-mode ON the normal receive path already forwards
			rlcmac_fwd <= in_loop && rx_valid && sub_on_r
				&& rx_hdr_ok;
			ctrl_obey <= in_loop && rx_valid && rx_is_ctrl
				&& rx_hdr_ok && rx_tbf_msg;
			ul_tx_stop <= terminate;
			ul_discard <= terminate;
			to_packet_idle <= terminate;
		end
	end

	// loopback descriptor toward the uplink physical layer
	always_ff @(posedge clock) begin
		if (rst) begin
			lb_valid <= 1'b0;
			lb_dl_tn <= 3'h0;
			lb_ul_slots <= 8'h00;
			lb_span <= rblt_pkg::NORMAL_SPAN_BLOCKS;
			lb_drop_bits <= 5'h00;
		end else begin
			lb_valid <= do_loop;
			if (do_loop) begin
				lb_dl_tn <= rx_tn;
				lb_ul_slots <= ul_slots;
				lb_span <= resend_gmsk ? rblt_pkg::GMSK_SPAN_BLOCKS
					: rblt_pkg::NORMAL_SPAN_BLOCKS;
				lb_drop_bits <= resend_gmsk ? rblt_pkg::GMSK_DROP_BITS
					: 5'h00;
			end
		end
	end

	// read data one cycle after the strobe, unmapped reads give zero
	logic [rblt_pkg::DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		unique case (reg_addr)
			rblt_pkg::OFS_CTRL:
				rd_mux[1:0] = ctrl_r;
			rblt_pkg::OFS_DL_MASK:
				rd_mux[7:0] = dl_mask_r;
			rblt_pkg::OFS_UL_MASK:
				rd_mux[7:0] = ul_mask_r;
			rblt_pkg::OFS_STATUS: begin
				rd_mux[rblt_pkg::STAT_ACTIVE_BIT] = in_loop;
				rd_mux[rblt_pkg::STAT_SUB_ON_BIT] = in_loop && sub_on_r;
				rd_mux[rblt_pkg::STAT_REQ_BIT] =
					state_r == rblt_pkg::RBLT_REQ;
				rd_mux[rblt_pkg::STAT_DL_OFS_LSB +: 3] = dl_ofs_r;
				rd_mux[rblt_pkg::STAT_DL_CNT_LSB +: 4] = dl_cnt;
				rd_mux[rblt_pkg::STAT_UL_CNT_LSB +: 4] = ul_cnt;
			end
			rblt_pkg::OFS_LB_COUNT:
				rd_mux[15:0] = lb_count_r;
			default:
				rd_mux = '0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= '0;
	end
endmodule
`default_nettype wire

// File: tb/rblt_ctrl_props.sv
// port assertions for the loopback controller
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
module rblt_ctrl_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic start_cmd,
	input wire logic tbf_release,
	input wire logic t3190_expired,
	input wire logic rx_valid,
	input wire logic rx_is_ctrl,
	input wire logic [1:0] rx_payload_type,
	input wire logic rx_hdr_ok,
	input wire logic rx_tbf_msg,
	input wire logic ul_tbf_req,
	input wire logic ul_rlc_unack,
	input wire logic loop_active,
	input wire logic sub_on,
	input wire logic llc_block,
	input wire logic tbf_hold_open,
	input wire logic t3180_disable,
	input wire logic t3164_disable,
	input wire logic own_tx_inhibit,
	input wire logic rlcmac_fwd,
	input wire logic ctrl_obey,
	input wire logic ul_discard,
	input wire logic to_packet_idle,
	input wire logic lb_valid,
	input wire logic [1:0] lb_span,
	input wire logic [4:0] lb_drop_bits
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// termination in the same cycle overrides the sub-mode switch, but not forwarding, obeying or looping
	wire logic calm = !tbf_release && !t3190_expired;
	unack_req_a: assert property (
		start_cmd && !llc_block |=> ul_tbf_req && ul_rlc_unack)
		else $error("no unacknowledged uplink request after start");
	enter_on_a: assert property ($rose(loop_active) |-> sub_on)
		else $error("loopback entered outside sub-mode on");
	hold_open_a: assert property (tbf_hold_open == loop_active &&
		t3180_disable == loop_active && t3164_disable == loop_active)
		else $error("flows not held open during loopback");
	llc_block_a: assert property (loop_active |-> llc_block)
		else $error("data reaches link layer in loopback");
	own_tx_a: assert property (own_tx_inhibit == sub_on)
		else $error("own uplink traffic not inhibited in sub-mode on");
	submode_sel_a: assert property (
		loop_active && rx_valid && rx_is_ctrl && calm
		|=> sub_on == !$past(rx_payload_type[0]))
		else $error("sub-mode does not follow payload type");
	off_quiet_a: assert property (
		loop_active && !sub_on && rx_valid |=> !lb_valid)
		else $error("block looped in sub-mode off");
	hdr_fwd_a: assert property (
		loop_active && sub_on && rx_valid && rx_hdr_ok && calm |=> rlcmac_fwd)
		else $error("decoded block not passed on");
	ctrl_obey_a: assert property (loop_active && rx_valid &&
		rx_is_ctrl && rx_hdr_ok && rx_tbf_msg && calm |=> ctrl_obey)
		else $error("flow control message not obeyed");
	term_idle_a: assert property (
		(tbf_release || t3190_expired) && llc_block
		|=> ul_discard && to_packet_idle && !llc_block && !loop_active)
		else $error("termination did not return to idle");
	drop_bits_a: assert property (lb_valid |->
		lb_drop_bits == (lb_span == 2'h3 ? 5'h10 : 5'h00))
		else $error("dropped bit count does not match span");
endmodule
bind rblt_ctrl rblt_ctrl_props chk (.*);
`default_nettype wire

// File: tb/rblt_sim.sv
// test equipment model: start command, grant, radio blocks, release
// assumes its tasks are called by the bench
`default_nettype none
module rblt_sim (
	input wire logic clock,
	input wire logic ul_tbf_req,
	output logic start_cmd,
	output logic [2:0] start_dl_offset,
	output logic ul_assigned,
	output logic tbf_release,
	output logic t3190_expired,
	output logic rx_valid,
	output logic [2:0] rx_tn,
	output logic rx_is_ctrl,
	output logic [1:0] rx_payload_type,
	output logic rx_hdr_ok,
	output logic rx_is_8psk,
	output logic rx_tbf_msg
);
	timeunit 1ns;
	timeprecision 1ns;
	bit psk_r = 0;
	initial {start_cmd, start_dl_offset, ul_assigned, tbf_release,
		t3190_expired, rx_valid, rx_tn, rx_is_ctrl, rx_payload_type,
		rx_hdr_ok, rx_is_8psk, rx_tbf_msg} = '0;
	task automatic start(input logic [2:0] ofs, output bit ok);
		ok = 0;
		@(posedge clock);
		start_cmd <= 1'b1;
		start_dl_offset <= ofs;
		@(posedge clock);
		start_cmd <= 1'b0;
		start_dl_offset <= ~ofs;
		for (int i = 0; i < 20 && !ok; i++) begin
			@(negedge clock);
			ok = ul_tbf_req;
		end
		repeat (3) @(posedge clock);
		ul_assigned <= 1'b1;
		@(posedge clock);
		ul_assigned <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	// f: ctrl, payload type(2), header ok, 8psk, flow message
	task automatic blk(input logic [2:0] tn, input logic [5:0] f);
		if (psk_r) repeat (2) @(posedge clock);
		@(posedge clock);
		{rx_is_ctrl, rx_payload_type, rx_hdr_ok, rx_is_8psk, rx_tbf_msg} <= f;
		rx_tn <= tn;
		rx_valid <= 1'b1;
		psk_r = f[1];
		@(posedge clock);
		rx_valid <= 1'b0;
		rx_tn <= ~tn;
		rx_payload_type <= ~f[4:3];
	endtask
	task automatic stop(input logic t3190);
		@(posedge clock);
		tbf_release <= !t3190;
		t3190_expired <= t3190;
		@(posedge clock);
		tbf_release <= 1'b0;
		t3190_expired <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: tb/rblt_ctrl_bench.sv
// self-checking bench for the loopback controller
// assumes the equipment model drives every radio-side input
`default_nettype none
module rblt_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = '0, lb_ul_slots, dm, um, es;
	logic [31:0] reg_wdata = '0, reg_rdata, v, seed = 32'h73A8A206;
	logic start_cmd, ul_assigned, tbf_release, t3190_expired, rx_valid;
	logic rx_is_ctrl, rx_hdr_ok, rx_is_8psk, rx_tbf_msg, ul_tbf_req;
	logic [2:0] start_dl_offset, rx_tn, lb_dl_tn, ofs, tn;
	logic [1:0] rx_payload_type, lb_span;
	logic ul_rlc_unack, loop_active, sub_on, llc_block, tbf_hold_open;
	logic t3180_disable, t3164_disable, own_tx_inhibit, rlcmac_fwd;
	logic ctrl_obey, ul_tx_stop, ul_discard, to_packet_idle, lb_valid;
	logic [4:0] lb_drop_bits;
	int fails = 0, n_compared = 0, nl = 0;
	bit ok, on;
	always #50 clock = ~clock;
	rblt_ctrl DUT (.*);
	rblt_sim sim (.*);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_slots(input logic [7:0] d, u,
		input logic [2:0] o, t, input logic m);
		int r, n, c;
		logic [2:0] s;
		r = 0;
		n = 0;
		c = 0;
		exp_slots = '0;
		for (int k = 0; k < 8; k++) begin
			s = o + 3'(k);
			if (d[s]) begin
				if (s == t) r = n;
				n++;
			end
		end
		if (!m || n < 2) return u;
		for (int k = 0; k < 8; k++) if (u[k]) begin
			if (c == r || (c > r && r == n - 1)) exp_slots[k] = 1'b1;
			c++;
		end
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rd(rblt_pkg::OFS_UL_MASK, v);
		chk(v, 32'(rblt_pkg::UL_MASK_RST));
		rd(8'h14, v);
		chk(v, 32'h0);
		// ctrl bits walk all four combinations over the sessions
		for (int s = 0; s < 8; s++) begin
			v = rnd();
			dm = v[7:0] | (8'h01 << v[10:8]);
			um = v[15:8] | (8'h01 << v[18:16]);
			ofs = v[21:19];
			wr(rblt_pkg::OFS_CTRL, 32'(s % 4));
			wr(rblt_pkg::OFS_DL_MASK, {24'h0, dm});
			wr(rblt_pkg::OFS_UL_MASK, {24'h0, um});
			// a write to the count register clears the loop counter, nothing loops meanwhile
			wr(rblt_pkg::OFS_LB_COUNT, 32'h0);
			nl = 0;
			sim.start(ofs, ok);
			chk(ok, 1);
			if (!ok) end_sim();
			@(negedge clock);
			chk({loop_active, sub_on, llc_block}, 3'h7);
			on = 1;
			repeat (24) begin
				v = rnd();
				tn = v[2:0];
				while (!dm[tn]) tn++;
				sim.blk(tn, v[8:3]);
				@(negedge clock);
				es = exp_slots(dm, um, ofs, tn, s[0]);
				chk(lb_valid, on && es != 0);
				if (on && es != 0) begin
					nl++;
					chk(lb_ul_slots, es);
					chk(lb_dl_tn, tn);
					chk(lb_span, (v[4] && s[1]) ? 3 : 1);
					chk(lb_drop_bits, (v[4] && s[1]) ? 16 : 0);
				end
				chk(rlcmac_fwd, on && v[5]);
				chk(ctrl_obey, v[8] && v[5] && v[3]);
				if (v[8]) on = !v[6];
				chk(sub_on, on);
			end
			rd(rblt_pkg::OFS_LB_COUNT, v);
			chk(v, 32'(nl));
			rd(rblt_pkg::OFS_STATUS, v);
			chk(v, {16'h0, 4'($countones(um)),
				4'($countones(dm)), 1'b0, ofs, 2'h0, on, 1'b1});
			sim.stop(s[0]);
			@(negedge clock);
			chk({ul_tx_stop, ul_discard, to_packet_idle, loop_active}, 4'hE);
		end
		end_sim();
	end
endmodule
`default_nettype wire
